// *** design/ranging_trigger_ctrl.sv ***
// Measurement sequencing and trigger / ready signalling of the transceiver
//
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/1ps

// Function
// - Free-running mode self-starts at programmed slow-reference rate
// - Free-running mode drives a chosen event pin
// - Free-running mode pulses pin low per sample
// - Hardware mode idles until trigger low pulse
// - Start fixed cycles after trigger falling edge
// - Same pin both ways, or split pins
// - Software mode starts on host register write
// - Software mode pulses pin low when done
// - Range setting sets listen phase length
// - Range is one-way distance to target
module ranging_trigger_ctrl
  import ranging_pkg::*;
#(
  parameter int TX_CYCLES     = TX_BURST_CYC,
  parameter int LISTEN_PER_MM = LISTEN_CYC_PER_MM
) (
  // Clock and reset
  input  wire logic              CORE_CLK,
  input  wire logic              RESET,
  // Register port
  input  wire logic [ADDR_W-1:0] REG_ADDR,
  input  wire logic [DATA_W-1:0] REG_WDATA,
  input  wire logic              REG_WR,
  input  wire logic              REG_RD,
  output logic      [DATA_W-1:0] REG_RDATA,
  // Open-drain event pins, index 0 is pin a, 1 is pin b
  input  wire logic [1:0]        EVENT_PIN_IN,
  output logic      [1:0]        EVENT_PIN_OUT,
  output logic      [1:0]        EVENT_PIN_OE,
  // External slow reference clock, sampled
  input  wire logic              SLOW_REFERENCE_CLOCK,
  // Measurement phases to the transducer front end
  output logic                   TX_ENABLE,
  output logic                   RX_ENABLE,
  output logic                   MEAS_BUSY,
  // Interrupt
  output logic                   IRQ
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic pick(input logic [1:0] v, input logic sel);
    pick = sel ? v[1] : v[0];
  endfunction

  function automatic logic fell(input logic prev, input logic cur);
    fell = prev & ~cur;
  endfunction

  localparam logic [PHASE_W-1:0] LATENCY_LOAD =
    PHASE_W'(TRIG_LATENCY_CYC - 1);
  localparam logic [PHASE_W-1:0] TX_LOAD   = PHASE_W'(TX_CYCLES - 1);
  localparam logic [PHASE_W-1:0] READY_LOAD = PHASE_W'(READY_PULSE_CYC - 1);
  localparam logic [15:0] SLOW_DIV_LAST = 16'(SLOW_DIV_CYC - 1);
  localparam logic [10:0] PER_MM = 11'(LISTEN_PER_MM);

  // ----------------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------------
  ctrl_t              ctrl;
  logic [DATA_W-1:0]  rate;
  logic [DATA_W-1:0]  full_scale_range;
  logic [IRQ_W-1:0]   irq_status;
  logic [IRQ_W-1:0]   irq_mask;
  logic [DATA_W-1:0]  sample_count;

  meas_state_t        state;
  meas_state_t        next_state;
  logic [PHASE_W-1:0] phase_cnt;
  logic               phase_done;
  ctrl_t              run_cfg;

  logic [1:0]         pin_meta;
  logic [1:0]         pin_sync;
  logic [1:0]         pin_prev;
  logic               ref_meta;
  logic               ref_sync;
  logic               ref_prev;

  logic [15:0]        div_cnt;
  logic               int_tick;
  logic               slow_tick;
  logic [DATA_W-1:0]  rate_cnt;
  logic               free_fire;
  logic               hw_fire;
  logic               sw_fire;
  logic               start;
  logic               idle;
  logic               wr_trigger;
  logic [IRQ_W-1:0]   irq_set;
  logic [IRQ_W-1:0]   irq_clr;
  logic [PHASE_W-1:0] listen_load;

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      pin_meta <= 2'h3;
      pin_sync <= 2'h3;
      pin_prev <= 2'h3;
    end else begin
      pin_meta <= EVENT_PIN_IN;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      ref_meta <= 1'b0;
      ref_sync <= 1'b0;
      ref_prev <= 1'b0;
    end else begin
      ref_meta <= SLOW_REFERENCE_CLOCK;
      ref_sync <= ref_meta;
      ref_prev <= ref_sync;
    end
  end

  // ----------------------------------------------------------------------
  // Slow reference and free-running pacing
  // ----------------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      div_cnt  <= 16'h0000;
      int_tick <= 1'b0;
    end else begin
      int_tick <= (div_cnt == SLOW_DIV_LAST);
      div_cnt  <= (div_cnt == SLOW_DIV_LAST) ? 16'h0000 : div_cnt + 16'h0001;
    end
  end

  // Rising edge of the external reference or the internal divider
  assign slow_tick = ctrl.ext_ref ? fell(ref_sync, ref_prev) : int_tick;

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      rate_cnt  <= 16'h0000;
      free_fire <= 1'b0;
    end else begin
      free_fire <= 1'b0;
      if (ctrl.mode != MODE_FREE) begin
        rate_cnt <= 16'h0000;
      end else if (slow_tick) begin
        if (rate_cnt + 16'h0001 >= rate) begin
          rate_cnt  <= 16'h0000;
          free_fire <= 1'b1;
        end else begin
          rate_cnt <= rate_cnt + 16'h0001;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Trigger sources
  // ----------------------------------------------------------------------
  // Falling edge on the selected pin only; own ready pulses fall in NOTIFY
  assign hw_fire = (ctrl.mode == MODE_HW)
                 & fell(pick(pin_prev, ctrl.trig_sel),
                        pick(pin_sync, ctrl.trig_sel));
  assign wr_trigger = REG_WR & (REG_ADDR == OFS_TRIGGER)
                    & REG_WDATA[TRIGGER_BIT];
  assign sw_fire = wr_trigger & (ctrl.mode == MODE_SW);
  assign idle    = (state == ST_IDLE);
  assign start   = idle & (free_fire | hw_fire | sw_fire);

  // ----------------------------------------------------------------------
  // Measurement sequencer
  // ----------------------------------------------------------------------
  assign phase_done  = (phase_cnt == '0);
  // One-way range doubled inside the per-millimetre figure
  assign listen_load = PHASE_W'(full_scale_range)
                     * PHASE_W'(PER_MM);

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (start) begin
          next_state = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (phase_done) begin
          next_state = ST_TX;
        end
      end
      ST_TX: begin
        if (phase_done) begin
          next_state = ST_LISTEN;
        end
      end
      ST_LISTEN: begin
        if (phase_done) begin
          next_state = ST_NOTIFY;
        end
      end
      ST_NOTIFY: begin
        if (phase_done) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      phase_cnt <= '0;
    end else if (state != next_state) begin
      unique case (next_state)
        ST_DELAY:  phase_cnt <= LATENCY_LOAD;
        ST_TX:     phase_cnt <= TX_LOAD;
        ST_LISTEN: phase_cnt <= listen_load;
        ST_NOTIFY: phase_cnt <= READY_LOAD;
        default:   phase_cnt <= '0;
      endcase
    end else if (!phase_done) begin
      phase_cnt <= phase_cnt - PHASE_W'(1);
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      run_cfg <= ctrl_t'(CTRL_RESET);
    end else if (start) begin
      run_cfg <= ctrl;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs from flops
  // ----------------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      TX_ENABLE <= 1'b0;
      RX_ENABLE <= 1'b0;
      MEAS_BUSY <= 1'b0;
    end else begin
      TX_ENABLE <= (next_state == ST_TX);
      RX_ENABLE <= (next_state == ST_LISTEN);
      MEAS_BUSY <= (next_state != ST_IDLE);
    end
  end

  // Open drain: only ever pulls low, enabled during the ready pulse
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      EVENT_PIN_OUT <= 2'h0;
      EVENT_PIN_OE  <= 2'h0;
    end else begin
      EVENT_PIN_OUT <= 2'h0;
      EVENT_PIN_OE  <= '0;
      if (next_state == ST_NOTIFY) begin
        EVENT_PIN_OE[run_cfg.rdy_sel] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      ctrl             <= ctrl_t'(CTRL_RESET);
      rate             <= RATE_RESET;
      full_scale_range <= RANGE_RESET;
      irq_mask         <= MASK_RESET;
    end else if (REG_WR) begin
      unique case (REG_ADDR)
        OFS_CTRL:     ctrl             <= ctrl_t'(REG_WDATA[CTRL_W-1:0]);
        OFS_RATE:     rate             <= REG_WDATA;
        OFS_RANGE:    full_scale_range <= REG_WDATA;
        OFS_IRQ_MASK: irq_mask         <= REG_WDATA[IRQ_W-1:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      sample_count <= 16'h0000;
    end else if (state == ST_LISTEN && phase_done) begin
      sample_count <= sample_count + 16'h0001;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt status, set wins over clear
  // ----------------------------------------------------------------------
  always_comb begin
    irq_set                = '0;
    irq_set[IRQ_DONE]      = (state == ST_LISTEN) & phase_done;
    irq_set[IRQ_TRIG_LOST] = ~idle & (hw_fire | sw_fire);
    irq_set[IRQ_OVERRUN]   = ~idle & free_fire;
    irq_clr = (REG_WR && REG_ADDR == OFS_IRQ_STATUS)
            ? REG_WDATA[IRQ_W-1:0] : '0;
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(((irq_status & ~irq_clr) | irq_set) & irq_mask);
    end
  end

  // ----------------------------------------------------------------------
  // Read data, valid only in the cycle after the strobe
  // ----------------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      REG_RDATA <= '0;
    end else begin
      REG_RDATA <= '0;
      if (REG_RD) begin
        unique case (REG_ADDR)
          OFS_CTRL:       REG_RDATA <= DATA_W'(ctrl);
          OFS_RATE:       REG_RDATA <= rate;
          OFS_RANGE:      REG_RDATA <= full_scale_range;
          OFS_STATUS:     REG_RDATA <= {12'h000, ~idle, state};
          OFS_IRQ_STATUS: REG_RDATA <= DATA_W'(irq_status);
          OFS_IRQ_MASK:   REG_RDATA <= DATA_W'(irq_mask);
          OFS_COUNT:      REG_RDATA <= sample_count;
          default:        REG_RDATA <= '0;
        endcase
      end
    end
  end

endmodule // ranging_trigger_ctrl

// *** dv/host_gpio_model.sv ***
// Host side of the open-drain event pins
`timescale 1ns/1ps
module host_gpio_model
  import ranging_pkg::*;
#(
  parameter int PULSE_CYC = 3
) (
  // Clock and request
  input  wire logic       clk,
  input  wire logic       fire,
  input  wire logic       pin_sel,
  // Device drive
  input  wire logic [1:0] dev_out,
  input  wire logic [1:0] dev_oe,
  // Resolved pin levels
  output logic [1:0]      level
);
  logic [1:0] pull = 2'b00;
  int         cnt = 0;

  // Low trigger pulse on the chosen pin
  always @(posedge clk) begin
    if (fire) begin
      pull <= 2'b01 << pin_sel;
      cnt <= PULSE_CYC;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else begin
      pull <= 2'b00;
      cnt <= 0;
    end
  end

  // Pull-up unless either side pulls low
  assign level = ~(pull | (dev_oe & ~dev_out));
endmodule // host_gpio_model

// *** dv/ranging_trigger_ctrl_assertions.sv ***
// Port-level checks of the trigger control block
`timescale 1ns/1ps
module ranging_trigger_checker
  import ranging_pkg::*;
#(
  parameter int TX_CYCLES     = 4,
  parameter int LISTEN_PER_MM = 1
) (
  // Clock and reset
  input wire logic              CORE_CLK,
  input wire logic              RESET,
  // Register writes
  input wire logic [ADDR_W-1:0] REG_ADDR,
  input wire logic [DATA_W-1:0] REG_WDATA,
  input wire logic              REG_WR,
  // Pins and phases
  input wire logic [1:0]        EVENT_PIN_IN,
  input wire logic [1:0]        EVENT_PIN_OE,
  input wire logic              TX_ENABLE,
  input wire logic              RX_ENABLE,
  input wire logic              MEAS_BUSY,
  input wire logic              IRQ
);
  ctrl_t             ctrl;
  logic [DATA_W-1:0] range;
  logic [IRQ_W-1:0]  mask;
  logic              trig_wr;
  logic              trig_in;
  int                listen_len;
  int                tx_cnt;
  int                rx_cnt;
  int                oe_cnt;

  // Cycles from busy rising to transmit rising
  localparam int LAUNCH_GAP = TRIG_LATENCY_CYC;

  assign trig_wr = REG_WR && REG_ADDR == OFS_TRIGGER
                   && REG_WDATA[TRIGGER_BIT];
  assign trig_in = EVENT_PIN_IN[ctrl.trig_sel];
  // Counter loads range times LISTEN_PER_MM, then runs down through zero
  assign listen_len = int'(range) * LISTEN_PER_MM + 1;

  // Shadow of configuration writes
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      ctrl  <= ctrl_t'(CTRL_RESET);
      range <= RANGE_RESET;
      mask  <= MASK_RESET;
    end else if (REG_WR) begin
      if (REG_ADDR == OFS_CTRL) ctrl <= ctrl_t'(REG_WDATA[CTRL_W-1:0]);
      if (REG_ADDR == OFS_RANGE) range <= REG_WDATA;
      if (REG_ADDR == OFS_IRQ_MASK) mask <= REG_WDATA[IRQ_W-1:0];
    end
  end

  // Length of the current high run of each phase
  always_ff @(posedge CORE_CLK) begin
    tx_cnt <= TX_ENABLE ? tx_cnt + 1 : 0;
    rx_cnt <= RX_ENABLE ? rx_cnt + 1 : 0;
    oe_cnt <= (|EVENT_PIN_OE) ? oe_cnt + 1 : 0;
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);

  sequence s_launch;
    !TX_ENABLE ##LAUNCH_GAP TX_ENABLE;
  endsequence
  sequence s_ready;
    EVENT_PIN_OE[ctrl.rdy_sel] && !RX_ENABLE;
  endsequence

  AST_SW_START: assert property (
    trig_wr && ctrl.mode == MODE_SW && !MEAS_BUSY |=> MEAS_BUSY)
    else $error("software trigger did not start");
  AST_LAUNCH: assert property ($rose(MEAS_BUSY) |-> s_launch)
    else $error("transmit not at fixed latency after start");
  AST_HW_EDGE: assert property (
    $rose(MEAS_BUSY) && ctrl.mode == MODE_HW
    |-> !$past(trig_in, 3) && $past(trig_in, 4))
    else $error("hardware start not tied to a falling edge");
  AST_TX_LEN: assert property (
    $fell(TX_ENABLE) |-> tx_cnt == TX_CYCLES && RX_ENABLE)
    else $error("transmit phase length wrong");
  AST_LISTEN_LEN: assert property (
    $fell(RX_ENABLE) |-> rx_cnt == listen_len)
    else $error("listen phase length wrong");
  AST_READY: assert property ($fell(RX_ENABLE) |-> s_ready)
    else $error("ready pin not pulled at end of listen");
  AST_READY_LEN: assert property (
    $fell(|EVENT_PIN_OE) |-> oe_cnt == READY_PULSE_CYC && !MEAS_BUSY)
    else $error("ready pulse length wrong");
  AST_IRQ_DONE: assert property (
    $fell(RX_ENABLE) && mask[IRQ_DONE] |=> IRQ)
    else $error("done interrupt not raised");
endmodule // ranging_trigger_checker

bind ranging_trigger_ctrl ranging_trigger_checker #(
  .TX_CYCLES(TX_CYCLES), .LISTEN_PER_MM(LISTEN_PER_MM)
) chk (
  .CORE_CLK(CORE_CLK), .RESET(RESET), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .EVENT_PIN_IN(EVENT_PIN_IN),
  .EVENT_PIN_OE(EVENT_PIN_OE), .TX_ENABLE(TX_ENABLE),
  .RX_ENABLE(RX_ENABLE), .MEAS_BUSY(MEAS_BUSY), .IRQ(IRQ)
);

// *** dv/tb.sv ***
// Self-checking bench of the trigger control block
`timescale 1ns/1ps
module tb;
  import ranging_pkg::*;
  localparam int RANGE_MM = 7;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic              wr = 1'b0;
  logic              rd = 1'b0;
  logic              slow_ref = 1'b0;
  logic              fire = 1'b0;
  logic              fire_pin = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic [1:0]        pin, pin_out, pin_oe;
  logic              tx, rx, busy, irq;
  int                err_count = 0;
  int                cmp_count = 0;
  int                ref_cnt = 0;

  always #5 clk = ~clk;
  // External slow reference, 400 cycles a period
  always @(posedge clk) begin
    ref_cnt <= (ref_cnt == 199) ? 0 : ref_cnt + 1;
    if (ref_cnt == 199) slow_ref <= ~slow_ref;
  end

  ranging_trigger_ctrl #(.TX_CYCLES(4), .LISTEN_PER_MM(1)) uut (
    .CORE_CLK(clk), .RESET(rst), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .EVENT_PIN_IN(pin),
    .EVENT_PIN_OUT(pin_out), .EVENT_PIN_OE(pin_oe),
    .SLOW_REFERENCE_CLOCK(slow_ref), .TX_ENABLE(tx), .RX_ENABLE(rx),
    .MEAS_BUSY(busy), .IRQ(irq)
  );
  host_gpio_model host (
    .clk(clk), .fire(fire), .pin_sel(fire_pin),
    .dev_out(pin_out), .dev_oe(pin_oe), .level(pin)
  );

  // ------
  // Access and compare tasks
  // ------
  task automatic chk(input string what, input logic [31:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input string what, logic [ADDR_W-1:0] a,
                        logic [DATA_W-1:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(what, e, rdata);
  endtask
  task automatic wait_busy(input logic v, output int n);
    n = 0;
    while (busy !== v && n < 8000) begin
      @(posedge clk);
      #1 n++;
    end
    if (n == 8000) chk("busy wait", v, ~v);
  endtask
  task automatic meas(output int rx_len, output logic [1:0] oe);
    int n;
    rx_len = 0;
    oe = 2'b00;
    wait_busy(1'b1, n);
    while (busy === 1'b1 && n < 8000) begin
      @(posedge clk);
      #1 rx_len += rx;
      oe |= pin_oe & ~pin;
      n++;
    end
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    #400000;
    err_count++;
    results();
  end

  // ------
  // Scenarios
  // ------
  initial begin
    int n, t, rxl;
    logic [1:0] oe;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd_chk("ctrl", OFS_CTRL, 16'h0000);
    rd_chk("rate", OFS_RATE, RATE_RESET);
    rd_chk("range", OFS_RANGE, RANGE_RESET);
    rd_chk("hole", 5'h02, 16'h0000);
    rd_chk("status idle", OFS_STATUS, 16'h0000);
    // Software trigger, masked then unmasked, retrigger dropped
    wr_reg(OFS_CTRL, 16'h000b);
    for (int i = 0; i < 2; i++) begin
      wr_reg(OFS_IRQ_MASK, 16'(i));
      wr_reg(OFS_RANGE, 16'(i * RANGE_MM));
      wr_reg(OFS_TRIGGER, 16'h0001);
      if (i == 1) wr_reg(OFS_TRIGGER, 16'h0001);
      meas(rxl, oe);
      chk("listen cycles", i ? RANGE_MM + 1 : 1, rxl);
      chk("sw ready pin", 2'b10, oe);
      chk("irq line", i, irq);
      rd_chk("irq status", OFS_IRQ_STATUS, 16'(2 * i + 1));
      wr_reg(OFS_IRQ_STATUS, 16'h0007);
      rd_chk("irq cleared", OFS_IRQ_STATUS, 16'h0000);
    end
    chk("irq low", 1'b0, irq);
    rd_chk("samples", OFS_COUNT, 16'h0002);
    // Hardware trigger on a shared pin, then split pins
    for (int i = 0; i < 2; i++) begin
      wr_reg(OFS_CTRL, i ? 16'h0006 : 16'h0002);
      repeat (20) @(posedge clk);
      chk("hw idle", 1'b0, busy);
      fire <= 1'b1;
      fire_pin <= i[0];
      @(posedge clk);
      fire <= 1'b0;
      #1 wait_busy(1'b1, n);
      if (i == 0) t = n;
      chk("hw latency", t, n);
      meas(rxl, oe);
      chk("hw ready pin", 2'b01, oe);
    end
    // Free running from external, then internal slow reference
    wr_reg(OFS_RATE, 16'h0001);
    for (int i = 0; i < 2; i++) begin
      wr_reg(OFS_CTRL, i ? 16'h0009 : 16'h0019);
      wait_busy(1'b1, n);
      wait_busy(1'b0, n);
      wait_busy(1'b1, t);
      chk("free interval", i ? SLOW_DIV_CYC : 400, n + t);
      meas(rxl, oe);
      chk("free ready pin", 2'b10, oe);
    end
    wr_reg(OFS_CTRL, 16'h0000);
    wait_busy(1'b0, n);
    results();
  end
endmodule // tb

// *** shared/ranging_pkg.sv ***
// Constants and types of the ranging measurement trigger control block
package ranging_pkg;

  // ----------------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;

  localparam logic [ADDR_W-1:0] OFS_CTRL       = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_RATE       = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_RANGE      = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_TRIGGER    = 5'h0c;
  localparam logic [ADDR_W-1:0] OFS_STATUS     = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 5'h14;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK   = 5'h18;
  localparam logic [ADDR_W-1:0] OFS_COUNT      = 5'h1c;

  // ----------------------------------------------------------------------
  // Modes, states and field layouts
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_OFF  = 2'b00,
    MODE_FREE = 2'b01,
    MODE_HW   = 2'b10,
    MODE_SW   = 2'b11
  } mode_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_DELAY  = 3'b001,
    ST_TX     = 3'b010,
    ST_LISTEN = 3'b011,
    ST_NOTIFY = 3'b100
  } meas_state_t;

  // Control word: bits [1:0] mode, 2 trigger pin, 3 ready pin, 4 ext ref
  typedef struct packed {
    logic  ext_ref;
    logic  rdy_sel;
    logic  trig_sel;
    mode_t mode;
  } ctrl_t;

  localparam int CTRL_W      = 5;
  localparam int TRIGGER_BIT = 0;

  localparam int IRQ_W         = 3;
  localparam int IRQ_DONE      = 0;
  localparam int IRQ_TRIG_LOST = 1;
  localparam int IRQ_OVERRUN   = 2;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [CTRL_W-1:0] CTRL_RESET  = 5'h00;
  localparam logic [DATA_W-1:0] RATE_RESET  = 16'h0bb8;
  localparam logic [DATA_W-1:0] RANGE_RESET = 16'h07d0;
  localparam logic [IRQ_W-1:0]  MASK_RESET  = 3'h0;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ          = 100;
  localparam int CLK_HZ           = CLK_MHZ * 1000000;
  localparam int SLOW_REF_HZ      = 30000;
  localparam int SLOW_DIV_CYC     = CLK_HZ / SLOW_REF_HZ;
  localparam int TRIG_LATENCY_NS  = 200;
  localparam int TRIG_LATENCY_CYC = (TRIG_LATENCY_NS * CLK_MHZ + 999) / 1000;
  localparam int TX_BURST_NS      = 100000;
  localparam int TX_BURST_CYC     = (TX_BURST_NS * CLK_MHZ + 999) / 1000;
  localparam int READY_PULSE_NS   = 2000;
  localparam int READY_PULSE_CYC  = (READY_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int SOUND_MM_PER_S   = 343000;
  // Round trip per millimetre of one-way range
  localparam int LISTEN_CYC_PER_MM = (2 * CLK_HZ) / SOUND_MM_PER_S;

  localparam int PHASE_W = 27;

endpackage : ranging_pkg
